/* File: include/fcc_pkg.sv */
// Shared constants and check-code functions for both link ends
package fcc_pkg;

  // ----------------------------------------------------------------
  // Check code constants
  // ----------------------------------------------------------------
  localparam logic [15:0] GENERATOR_POLYNOMIAL = 16'h4599;
  localparam logic [15:0] CRC_TOP_MASK         = 16'h4000;
  localparam logic [15:0] CRC_SEED             = 16'h0010;
  localparam logic [15:0] CRC_WIDTH_MASK       = 16'hFFFF;
  localparam logic [7:0]  CRC_IDX_MASK         = 8'hFF;
  localparam int          CRC_IDX_SHIFT        = 7;
  localparam int          CRC_BYTE_SHIFT       = 8;
  localparam int          LUT_STEPS            = 8;
  localparam int          LUT_ENTRIES          = 256;

  // ----------------------------------------------------------------
  // Frame layout: header, data, then two code bytes
  // ----------------------------------------------------------------
  localparam logic [8:0] HDR_SLOT    = 9'h000;
  localparam logic [8:0] CODE_HI_OFS = 9'h001;
  localparam logic [8:0] CODE_LO_OFS = 9'h002;
  localparam logic [7:0] FILL_BYTE   = 8'h00;
  localparam logic [6:0] STATUS_PAD  = 7'h00;

  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned SCK_MAX_KHZ       = 1000;
  localparam int unsigned SCK_MIN_PERIOD_NS = 1000000 / SCK_MAX_KHZ;
  localparam int unsigned FULL_RATE_CABLE_M = 10;
  localparam int unsigned LINK_BASE_NS      = 900;
  localparam int unsigned CABLE_DM_PER_NS   = 2;
  localparam int unsigned DM_PER_M          = 10;
  localparam int unsigned SYNC_MIN_HALF     = 3;

  // Half period of the link clock in core cycles, rounded up
  function automatic int unsigned sck_half_cycles(input int unsigned len_m);
    int unsigned dly_ns;
    int unsigned per_ns;
    int unsigned half;
    dly_ns = (len_m * DM_PER_M + CABLE_DM_PER_NS - 1) / CABLE_DM_PER_NS;
    per_ns = LINK_BASE_NS + 2 * dly_ns;
    if (per_ns < SCK_MIN_PERIOD_NS) per_ns = SCK_MIN_PERIOD_NS;
    half = (per_ns + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    if (half < SYNC_MIN_HALF) half = SYNC_MIN_HALF;
    return half;
  endfunction

  // One entry of the 256-entry lookup table
  function automatic logic [15:0] crc_lookup_table(input logic [7:0] idx);
    logic [15:0] r;
    r = {8'h00, idx} << CRC_IDX_SHIFT;
    for (int i = 0; i < LUT_STEPS; i++) begin
      if (|(r & CRC_TOP_MASK)) r = (r << 1) ^ GENERATOR_POLYNOMIAL; // [R3]
      else r = r << 1;
    end
    return r & CRC_WIDTH_MASK; // [R6]
  endfunction

  // Remainder update for one byte
  function automatic logic [15:0] crc_step(input logic [15:0] rem,
                                           input logic [7:0]  data);
    logic [15:0] t;
    logic [7:0]  idx;
    t   = (rem >> CRC_IDX_SHIFT) ^ {8'h00, data};
    idx = t[7:0] & CRC_IDX_MASK;
    return (rem << CRC_BYTE_SHIFT) ^ crc_lookup_table(idx);
  endfunction

  // Transmitted code: remainder times two, low bit zero
  function automatic logic [15:0] crc15_frame_code(input logic [15:0] rem);
    return rem << 1;
  endfunction

endpackage

/* File: include/fcc_link_if.sv */
// Serial link between host end and device end
`timescale 1ns/1ns
interface fcc_link_if;
  logic sclk;
  logic frame_act;
  logic mosi;
  logic miso;

  modport host_mp (
    output sclk,
    output frame_act,
    output mosi,
    input  miso
  );

  modport dev_mp (
    input  sclk,
    input  frame_act,
    input  mosi,
    output miso
  );
endinterface

/* File: core/fcc_host_end.sv */
// Host end: frames bytes with a check code and drives the link clock
//
// Function
// R1: Sender appends check code to every frame
// R2: Fifteen-bit code over any number of bytes
// R3: Polynomial 0x4599, top bit 0x4000 selects XOR
// R4: Remainder starts at seed 16 each frame
// R5: Index from remainder>>7 XOR byte, shift 8
// R6: Table entries from index<<7, eight polynomial steps
// R7: Code sent is remainder times two
// R8: Link clock at most 1MHz, full up to 10m
// R9: Period above 0.9us plus twice cable delay
// R10: Receiver recomputes code, flags mismatch as invalid
`timescale 1ns/1ns
module fcc_host_end #(
  parameter int unsigned CABLE_LEN_M = fcc_pkg::FULL_RATE_CABLE_M
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] len,
  output logic            busy,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_valid,
  output logic            wr_ready,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            done,
  output logic            crc_err,
  output logic [7:0]      dev_status,
  fcc_link_if.host_mp     lnk
);

  // ----------------------------------------------------------------
  // Types and constants
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FCC_IDLE  = 3'b000,
    FCC_ARM   = 3'b001,
    FCC_SHIFT = 3'b011,
    FCC_DONE  = 3'b010,
    FCC_WAIT  = 3'b111
  } fcc_host_state_t;

  localparam logic [15:0] HALF_CYC =
    16'(fcc_pkg::sck_half_cycles(CABLE_LEN_M)); // [R8] [R9]
  localparam logic [15:0] DIV_ONE  = 16'h0001;
  localparam logic [2:0]  LAST_BIT = 3'h7;
  localparam logic [1:0]  FIFO_CAP = 2'h2;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fcc_host_state_t state_reg;
  logic [15:0]     div_reg;
  logic            sclk_reg;
  logic            frame_reg;
  logic            mosi_reg;
  logic            miso_meta_reg;
  logic            miso_sync_reg;
  logic [2:0]      bit_reg;
  logic [8:0]      slot_reg;
  logic [7:0]      len_reg;
  logic [6:0]      tx_sh_reg;
  logic [15:0]     tx_rem_reg;
  logic [6:0]      rx_sh_reg;
  logic [15:0]     rx_rem_reg;
  logic [7:0]      rx_hi_reg;
  logic [7:0]      rd_data_reg;
  logic            rd_valid_reg;
  logic            done_reg;
  logic            crc_err_reg;
  logic [7:0]      status_reg;
  logic [7:0]      fifo_mem [2];
  logic            fifo_wptr_reg;
  logic            fifo_rptr_reg;
  logic [1:0]      fifo_cnt_reg;

  logic            tick;
  logic            fall_tick;
  logic [8:0]      last_slot;
  logic [8:0]      nxt_slot;
  logic            nxt_is_data;
  logic [7:0]      nxt_byte;
  logic [15:0]     tx_code;
  logic            fifo_valid;
  logic            fifo_push;
  logic            fifo_pop;
  logic            load_now;
  logic            sample_now;
  logic            byte_end;
  logic            finish;
  logic            go_wait;
  logic [7:0]      rx_byte;
  logic            rx_is_data;

  // ----------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------
  assign tick      = (div_reg == '0);
  assign fall_tick = tick && sclk_reg;

  // Half-period counter for the link clock
  always_ff @(posedge core_clk) begin
    if (rst || tick) begin
      div_reg <= HALF_CYC - DIV_ONE; // [R8] [R9]
    end else begin
      div_reg <= div_reg - DIV_ONE;
    end
  end

  // Free running between frames, held low while waiting for data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_reg <= 1'b0;
    end else if (tick) begin
      sclk_reg <= (state_reg == FCC_WAIT) ? 1'b0 : ~sclk_reg;
    end
  end

  // Two-flop synchroniser for the returned data line
  always_ff @(posedge core_clk) begin
    if (rst) begin
      miso_meta_reg <= 1'b0;
      miso_sync_reg <= 1'b0;
    end else begin
      miso_meta_reg <= lnk.miso;
      miso_sync_reg <= miso_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Two-entry write buffer
  // ----------------------------------------------------------------
  assign wr_ready   = (fifo_cnt_reg != FIFO_CAP);
  assign fifo_valid = (fifo_cnt_reg != '0);
  assign fifo_push  = wr_valid && wr_ready;
  assign fifo_pop   = load_now && nxt_is_data;

  // Storage and pointers
  always_ff @(posedge core_clk) begin
    if (fifo_push) begin
      fifo_mem[fifo_wptr_reg] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fifo_wptr_reg <= 1'b0;
      fifo_rptr_reg <= 1'b0;
      fifo_cnt_reg  <= '0;
    end else begin
      if (fifo_push) fifo_wptr_reg <= ~fifo_wptr_reg;
      if (fifo_pop) fifo_rptr_reg <= ~fifo_rptr_reg;
      fifo_cnt_reg <= fifo_cnt_reg + {1'b0, fifo_push}
                      - {1'b0, fifo_pop};
    end
  end

  // ----------------------------------------------------------------
  // Slot sequencing
  // ----------------------------------------------------------------
  assign last_slot  = {1'b0, len_reg} + fcc_pkg::CODE_LO_OFS;
  assign tx_code    = fcc_pkg::crc15_frame_code(tx_rem_reg); // [R7]
  assign sample_now = (state_reg == FCC_SHIFT) && fall_tick;
  assign byte_end   = sample_now && (bit_reg == LAST_BIT);
  assign finish     = byte_end && (slot_reg == last_slot);

  // Next slot and the byte it carries
  always_comb begin
    nxt_slot = (state_reg == FCC_ARM) ? fcc_pkg::HDR_SLOT
                                      : slot_reg + 9'h001;
    nxt_is_data = (nxt_slot != fcc_pkg::HDR_SLOT)
                  && (nxt_slot <= {1'b0, len_reg});
    if (nxt_slot == fcc_pkg::HDR_SLOT) begin
      nxt_byte = len_reg;
    end else if (nxt_is_data) begin
      nxt_byte = fifo_mem[fifo_rptr_reg];
    end else if (nxt_slot == {1'b0, len_reg} + fcc_pkg::CODE_HI_OFS) begin
      nxt_byte = tx_code[15:8]; // [R1]
    end else begin
      nxt_byte = tx_code[7:0]; // [R1]
    end
  end

  // Load decisions at fall points, and at the resume tick in the wait state
  assign go_wait  = byte_end && !finish && nxt_is_data && !fifo_valid;
  assign load_now = ((state_reg == FCC_ARM) && fall_tick)
                    || ((state_reg == FCC_WAIT) && tick && fifo_valid)
                    || (byte_end && !finish && !go_wait);

  // Frame state machine
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= FCC_IDLE;
    end else begin
      unique case (state_reg)
        FCC_IDLE:  if (start) state_reg <= FCC_ARM;
        FCC_ARM:   if (fall_tick) state_reg <= FCC_SHIFT;
        FCC_SHIFT: begin
          if (finish) state_reg <= FCC_DONE;
          else if (go_wait) state_reg <= FCC_WAIT;
        end
        FCC_WAIT:  if (tick && fifo_valid) state_reg <= FCC_SHIFT;
        FCC_DONE:  state_reg <= FCC_IDLE;
      endcase
    end
  end

  // Length latched when a frame is requested
  always_ff @(posedge core_clk) begin
    if (rst) begin
      len_reg <= '0;
    end else if ((state_reg == FCC_IDLE) && start) begin
      len_reg <= len;
    end
  end

  // Frame enable on the link
  always_ff @(posedge core_clk) begin
    if (rst) begin
      frame_reg <= 1'b0;
    end else if ((state_reg == FCC_ARM) && fall_tick) begin
      frame_reg <= 1'b1;
    end else if (finish) begin
      frame_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bit_reg    <= '0;
      slot_reg   <= '0;
      mosi_reg   <= 1'b0;
      tx_sh_reg  <= '0;
      tx_rem_reg <= fcc_pkg::CRC_SEED;
    end else if (load_now) begin
      slot_reg  <= nxt_slot;
      bit_reg   <= '0;
      mosi_reg  <= nxt_byte[7];
      tx_sh_reg <= nxt_byte[6:0];
      if (nxt_slot == fcc_pkg::HDR_SLOT) begin
        tx_rem_reg <= fcc_pkg::crc_step(fcc_pkg::CRC_SEED, nxt_byte); // [R4]
      end else if (nxt_is_data) begin
        tx_rem_reg <= fcc_pkg::crc_step(tx_rem_reg, nxt_byte); // [R2] [R5]
      end
    end else if (sample_now && (bit_reg != LAST_BIT)) begin
      bit_reg   <= bit_reg + 3'h1;
      mosi_reg  <= tx_sh_reg[6];
      tx_sh_reg <= tx_sh_reg << 1;
    end
  end

  // ----------------------------------------------------------------
  // Receive path and check
  // ----------------------------------------------------------------
  assign rx_byte    = {rx_sh_reg, miso_sync_reg};
  assign rx_is_data = (slot_reg != fcc_pkg::HDR_SLOT)
                      && (slot_reg <= {1'b0, len_reg});

  // Shift in one bit per fall point
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_sh_reg <= '0;
    end else if (sample_now) begin
      rx_sh_reg <= rx_byte[6:0];
    end
  end

  // Remainder, status, high code byte and data output
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_rem_reg  <= fcc_pkg::CRC_SEED;
      rx_hi_reg   <= '0;
      status_reg  <= '0;
      rd_data_reg <= '0;
    end else if (byte_end) begin
      if (slot_reg == fcc_pkg::HDR_SLOT) begin
        status_reg <= rx_byte;
        rx_rem_reg <= fcc_pkg::crc_step(fcc_pkg::CRC_SEED, rx_byte); // [R4]
      end else if (rx_is_data) begin
        rd_data_reg <= rx_byte;
        rx_rem_reg  <= fcc_pkg::crc_step(rx_rem_reg, rx_byte); // [R5]
      end else if (!finish) begin
        rx_hi_reg <= rx_byte;
      end
    end
  end

  // Pulses and the mismatch flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_valid_reg <= 1'b0;
      done_reg     <= 1'b0;
      crc_err_reg  <= 1'b0;
    end else begin
      rd_valid_reg <= byte_end && rx_is_data;
      done_reg     <= finish;
      if (finish) begin
        crc_err_reg <= ({rx_hi_reg, rx_byte}
                        != fcc_pkg::crc15_frame_code(rx_rem_reg)); // [R10]
      end else if ((state_reg == FCC_IDLE) && start) begin
        crc_err_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign busy          = (state_reg != FCC_IDLE);
  assign rd_data       = rd_data_reg;
  assign rd_valid      = rd_valid_reg;
  assign done          = done_reg;
  assign crc_err       = crc_err_reg;
  assign dev_status    = status_reg;
  assign lnk.sclk      = sclk_reg;
  assign lnk.frame_act = frame_reg;
  assign lnk.mosi      = mosi_reg;

endmodule

/* File: core/fcc_dev_end.sv */
// Device end: checks host frames and answers with coded data
`timescale 1ns/1ns
module fcc_dev_end (
  fcc_link_if.dev_mp      lnk,
  input  wire logic       rst,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            frame_done,
  output logic            crc_err
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [2:0] LAST_BIT = 3'h7;

  logic [2:0]  bit_reg;
  logic [8:0]  slot_reg;
  logic [7:0]  len_reg;
  logic [6:0]  rx_sh_reg;
  logic [6:0]  tx_sh_reg;
  logic        miso_reg;
  logic [15:0] rx_rem_reg;
  logic [15:0] tx_rem_reg;
  logic [7:0]  rx_hi_reg;
  logic [7:0]  rx_data_reg;
  logic        rx_valid_reg;
  logic        done_reg;
  logic        err_reg;

  logic [7:0]  rx_byte;
  logic        slot_data;
  logic [15:0] tx_code;
  logic [7:0]  tx_byte;
  logic [15:0] tx_base;
  logic [15:0] rx_base;

  // ----------------------------------------------------------------
  // Slot decode
  // ----------------------------------------------------------------
  assign rx_byte   = {rx_sh_reg, lnk.mosi};
  assign slot_data = (slot_reg != fcc_pkg::HDR_SLOT)
                     && (slot_reg <= {1'b0, len_reg});
  assign tx_code   = fcc_pkg::crc15_frame_code(tx_rem_reg); // [R7]
  assign tx_base   = (slot_reg == fcc_pkg::HDR_SLOT) ? fcc_pkg::CRC_SEED
                                                     : tx_rem_reg; // [R4]
  assign rx_base   = (slot_reg == fcc_pkg::HDR_SLOT) ? fcc_pkg::CRC_SEED
                                                     : rx_rem_reg; // [R4]
  assign tx_ready  = lnk.frame_act && (bit_reg == '0) && slot_data;

  // Byte sent in the current slot
  always_comb begin
    if (slot_reg == fcc_pkg::HDR_SLOT) begin
      tx_byte = {fcc_pkg::STATUS_PAD, err_reg};
    end else if (slot_data) begin
      tx_byte = tx_valid ? tx_data : fcc_pkg::FILL_BYTE;
    end else if (slot_reg == {1'b0, len_reg} + fcc_pkg::CODE_HI_OFS) begin
      tx_byte = tx_code[15:8]; // [R1]
    end else begin
      tx_byte = tx_code[7:0]; // [R1]
    end
  end

  // ----------------------------------------------------------------
  // Bit and slot counters, restarted outside frames
  // ----------------------------------------------------------------
  always_ff @(posedge lnk.sclk) begin
    if (rst || !lnk.frame_act) begin
      bit_reg  <= '0;
      slot_reg <= '0;
    end else begin
      bit_reg <= bit_reg + 3'h1;
      if (bit_reg == LAST_BIT) slot_reg <= slot_reg + 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  always_ff @(posedge lnk.sclk) begin
    if (rst || !lnk.frame_act) begin
      miso_reg   <= 1'b0;
      tx_sh_reg  <= '0;
      tx_rem_reg <= fcc_pkg::CRC_SEED; // [R4]
    end else if (bit_reg == '0) begin
      miso_reg  <= tx_byte[7];
      tx_sh_reg <= tx_byte[6:0];
      if ((slot_reg == fcc_pkg::HDR_SLOT) || slot_data) begin
        tx_rem_reg <= fcc_pkg::crc_step(tx_base, tx_byte); // [R2] [R5]
      end
    end else begin
      miso_reg  <= tx_sh_reg[6];
      tx_sh_reg <= tx_sh_reg << 1;
    end
  end

  // ----------------------------------------------------------------
  // Receive path and check
  // ----------------------------------------------------------------
  always_ff @(posedge lnk.sclk) begin
    if (rst) begin
      rx_sh_reg <= '0;
    end else if (lnk.frame_act) begin
      rx_sh_reg <= rx_byte[6:0];
    end
  end

  // Length, remainder, data and high code byte
  always_ff @(posedge lnk.sclk) begin
    if (rst || !lnk.frame_act) begin
      rx_rem_reg <= fcc_pkg::CRC_SEED;
      if (rst) len_reg <= '0;
      if (rst) rx_hi_reg <= '0;
      if (rst) rx_data_reg <= '0;
    end else if (bit_reg == LAST_BIT) begin
      if (slot_reg == fcc_pkg::HDR_SLOT) begin
        len_reg    <= rx_byte;
        rx_rem_reg <= fcc_pkg::crc_step(rx_base, rx_byte); // [R5]
      end else if (slot_data) begin
        rx_data_reg <= rx_byte;
        rx_rem_reg  <= fcc_pkg::crc_step(rx_rem_reg, rx_byte); // [R5]
      end else if (slot_reg == {1'b0, len_reg} + fcc_pkg::CODE_HI_OFS) begin
        rx_hi_reg <= rx_byte;
      end
    end
  end

  // Pulses and the mismatch flag
  always_ff @(posedge lnk.sclk) begin
    if (rst) begin
      rx_valid_reg <= 1'b0;
      done_reg     <= 1'b0;
      err_reg      <= 1'b0;
    end else begin
      rx_valid_reg <= lnk.frame_act && (bit_reg == LAST_BIT) && slot_data;
      done_reg     <= 1'b0;
      if (lnk.frame_act && (bit_reg == LAST_BIT)
          && (slot_reg == {1'b0, len_reg} + fcc_pkg::CODE_LO_OFS)) begin
        done_reg <= 1'b1;
        err_reg  <= ({rx_hi_reg, rx_byte}
                     != fcc_pkg::crc15_frame_code(rx_rem_reg)); // [R10]
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rx_data    = rx_data_reg;
  assign rx_valid   = rx_valid_reg;
  assign frame_done = done_reg;
  assign crc_err    = err_reg;
  assign lnk.miso   = miso_reg;

endmodule

/* File: testbench/fcc_link_assertions.sv */
// Link checks: framing, check code and link clock timing
`timescale 1ns/1ns
module fcc_link_assertions #(
  parameter int unsigned CABLE_LEN_M = 10
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic dev_rst,
  input wire logic sclk,
  input wire logic frame_act,
  input wire logic mosi,
  input wire logic miso
);
  localparam int DLY = (CABLE_LEN_M * 10 + 1) / 2;
  localparam int PER = (900 + 2 * DLY < 1000) ? 1000 : 900 + 2 * DLY;
  localparam int HALF = (PER + 19) / 20;
  logic [11:0] cnt_reg;
  logic [7:0]  hdr_reg;
  logic [14:0] ra_reg;
  logic [15:0] hi_reg;
  logic [15:0] lo_reg;

  // One serial step of the check code
  function automatic logic [14:0] crc_bit(input logic [14:0] r,
                                          input logic        b);
    return {r[13:0], 1'b0} ^ ((r[14] ^ b) ? 15'h4599 : 15'h0000);
  endfunction

  // Bit count, header and running code over the whole frame
  always_ff @(posedge sclk) begin
    if (dev_rst || !frame_act) begin
      cnt_reg <= 12'h000;
      ra_reg  <= 15'h0010;
    end else begin
      cnt_reg <= cnt_reg + 12'h001;
      ra_reg  <= crc_bit(ra_reg, mosi);
      if (cnt_reg < 12'h008) hdr_reg <= {hdr_reg[6:0], mosi};
    end
  end

  // Core cycles spent in the high and low link clock phases
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hi_reg <= 16'h0000;
      lo_reg <= 16'hFFFF;
    end else begin
      hi_reg <= sclk ? hi_reg + 16'h0001 : 16'h0000;
      lo_reg <= sclk ? 16'h0000 : lo_reg + {15'h0000, lo_reg != 16'hFFFF};
    end
  end

  property p_frame_len;
    @(posedge sclk) disable iff (dev_rst)
      $fell(frame_act) |-> cnt_reg == ({4'h0, hdr_reg} + 12'h003) * 12'h008;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length differs from header");
  property p_frame_min;
    @(posedge sclk) disable iff (dev_rst)
      $rose(frame_act) |->
        frame_act [*8] ##1 frame_act [*8] ##1 frame_act [*8];
  endproperty
  a_frame_min: assert property (p_frame_min)
    else $error("frame shorter than three bytes");
  property p_code;
    @(posedge sclk) disable iff (dev_rst)
      $fell(frame_act) |-> ra_reg == 15'h0000;
  endproperty
  a_code: assert property (p_code)
    else $error("sent check code does not match data");
  property p_code_lsb;
    @(posedge sclk) disable iff (dev_rst) $fell(frame_act) |-> !$past(mosi);
  endproperty
  a_code_lsb: assert property (p_code_lsb)
    else $error("check code low bit not zero");
  property p_high_half;
    @(posedge core_clk) disable iff (rst) $fell(sclk) |-> hi_reg == HALF;
  endproperty
  a_high_half: assert property (p_high_half)
    else $error("link clock high phase wrong");
  property p_low_min;
    @(posedge core_clk) disable iff (rst) $rose(sclk) |-> lo_reg >= HALF;
  endproperty
  a_low_min: assert property (p_low_min)
    else $error("link clock low phase too short");
  property p_mosi_hold;
    @(posedge core_clk) disable iff (rst) sclk |-> $stable(mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("data bit moved while clock high");
  property p_act_hold;
    @(posedge core_clk) disable iff (rst) sclk |-> $stable(frame_act);
  endproperty
  a_act_hold: assert property (p_act_hold)
    else $error("frame flag moved while clock high");
  c_empty: cover property (@(posedge sclk) disable iff (dev_rst)
    $fell(frame_act) && hdr_reg == 8'h00);
  c_stall: cover property (@(posedge core_clk) disable iff (rst)
    $rose(sclk) && lo_reg > HALF);
  c_reply: cover property (@(posedge sclk) disable iff (dev_rst)
    frame_act && miso);
endmodule

/* File: testbench/frame_crc15_generator_checker_bench.sv */
// Bench: host and device ends joined, plus a faulty sender
`timescale 1ns/1ns
module frame_crc15_generator_checker_bench;
  localparam int unsigned CABLE_M = 10;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       dev_rst = 1'b1;
  logic       flt_rst = 1'b1;
  logic       start = 1'b0;
  logic [7:0] len = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic       wr_valid = 1'b0;
  logic [7:0] tx_data = 8'h10;
  logic       tx_pre = 1'b0;
  logic       dev_errs = 1'b0;
  logic       busy, wr_ready, rd_valid, done, crc_err, tx_ready;
  logic       rx_valid, frame_done, dev_err, flt_done, flt_err;
  logic [7:0] rd_data, dev_status, rx_data, flt_rx;
  logic [7:0] rdq[$];
  logic [7:0] rxq[$];
  logic [7:0] none[$];
  int         failures = 0;
  int         tests_run = 0;
  int         dones = 0;
  int         dev_dones = 0;
  int         flt_dones = 0;
  fcc_link_if lnk();
  fcc_link_if flt();

  fcc_host_end #(.CABLE_LEN_M(CABLE_M)) fcc_host_end_i (
    .core_clk(core_clk), .rst(rst), .start(start), .len(len), .busy(busy),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
    .crc_err(crc_err), .dev_status(dev_status), .lnk(lnk));
  fcc_dev_end fcc_dev_end_i (
    .lnk(lnk), .rst(dev_rst), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(1'b1), .tx_ready(tx_ready),
    .frame_done(frame_done), .crc_err(dev_err));
  fcc_dev_end fcc_dev_end_flt_i (
    .lnk(flt), .rst(flt_rst), .rx_data(flt_rx), .rx_valid(),
    .tx_data(8'h00), .tx_valid(1'b0), .tx_ready(),
    .frame_done(flt_done), .crc_err(flt_err));
  fcc_link_assertions #(.CABLE_LEN_M(CABLE_M)) fcc_link_assertions_i (
    .core_clk(core_clk), .rst(rst), .dev_rst(dev_rst), .sclk(lnk.sclk),
    .frame_act(lnk.frame_act), .mosi(lnk.mosi), .miso(lnk.miso));

  // Clock and collectors of received bytes and completions
  always #5 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
    if (done === 1'b1) dones++;
  end
  always @(negedge lnk.sclk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (frame_done === 1'b1) dev_dones++;
    if (frame_done === 1'b1) dev_errs = dev_errs | dev_err;
    tx_pre <= tx_ready;
  end
  // Device reply bytes step by 0x11 on each take
  always @(posedge lnk.sclk)
    if (tx_pre === 1'b1) tx_data <= #1 tx_data + 8'h11;
  always @(negedge flt.sclk) if (flt_done === 1'b1) flt_dones++;

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One host frame; a stall before the third byte starves the sender
  task automatic run_frame(input logic [7:0] d[$], input int stall);
    int n;
    n = dones;
    start = 1'b1;
    len = 8'(d.size());
    #10 check("busy", {15'h0000, busy}, 16'h0001);
    #10 start = 1'b0;
    foreach (d[k]) begin
      if (k == 2) wr_valid = 1'b0;
      if (k == 2) #(stall * 10);
      wr_data = d[k];
      wr_valid = 1'b1;
      while (wr_ready !== 1'b1) #10;
      #10;
    end
    wr_valid = 1'b0;
    for (int t = 0; t < 20000 && dones == n; t++) #10;
    check("done", 16'(dones - n), 16'h0001);
    check("host err", {15'h0000, crc_err}, 16'h0000);
    check("status", {8'h00, dev_status}, 16'h0000);
  endtask

  // Faulty sender on the second link, clock runs only while sending
  task automatic flt_bits(input logic [31:0] v, input logic act, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      flt.frame_act = act;
      flt.mosi = v[i];
      #8 flt.sclk = 1'b1;
      #7 flt.sclk = 1'b0;
    end
  endtask

  // Main sequence
  initial begin
    flt.sclk = 1'b0;
    flt.frame_act = 1'b0;
    flt.mosi = 1'b0;
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge lnk.sclk);
    #1 dev_rst = 1'b0;
    @(posedge core_clk);
    #1 run_frame('{8'hA5, 8'h00, 8'hFF}, 3000);
    run_frame(none, 0);
    flt_bits(32'hAAAAAAAA, 1'b0, 3);
    flt_rst = 1'b0;
    flt_bits({8'h01, 8'h5A, 16'h0001}, 1'b1, 32);
    flt_bits(32'h55555555, 1'b0, 3);
    check("rx count", 16'(rxq.size()), 16'h0003);
    check("rx 0", {8'h00, rxq[0]}, 16'h00A5);
    check("rx 1", {8'h00, rxq[1]}, 16'h0000);
    check("rx 2", {8'h00, rxq[2]}, 16'h00FF);
    check("rd count", 16'(rdq.size()), 16'h0003);
    foreach (rdq[k])
      check("rd", {8'h00, rdq[k]}, 16'(8'h10 + 8'h11 * k));
    check("dev frames", 16'(dev_dones), 16'h0002);
    check("dev err", {15'h0000, dev_errs}, 16'h0000);
    check("flt frames", 16'(flt_dones), 16'h0001);
    check("flt err", {15'h0000, flt_err}, 16'h0001);
    check("flt rx", {8'h00, flt_rx}, 16'h005A);
    give_verdict();
  end

  // Watchdog against a hung frame
  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    give_verdict();
  end
endmodule
